// ===== shared/adc_card_pkg.sv
// Overview of operation
// - Claim eight I/O addresses; upper bits match switch base, low three select register.
// - Upper nibble of either control register write updates the four general outputs.
// - First control register bit 3 enables interrupt generation.
// - First control register bits 2..0 drive the multiplexer channel address.
// - Second control register bit 3 drives a spare user output line.
// - Second control register bits 2..0 drive the expansion gain select lines.
// - Status bit 7 is one while converting, zero when result valid.
// - Status echoes gain lines in bits 6..4 and channel address in 2..0.
// - Status bit 3 sets whenever an interrupt is generated.
// - Interrupt status clears on reset, conversion start, or a control register write outside a conversion-end cycle.
// - Result captured as unsigned binary at the end of every conversion.
// - Captured result stays unchanged until the next conversion finishes.
// - Offset 0 read: low four result bits high, general outputs low nibble.
// - Offset 1 read: upper eight result bits, top bit in bit 7.
// - Low then high byte reads come from the same captured conversion only if no conversion ends between them.
// - A write to offset 1 while idle starts a conversion and raises busy until done; writes while busy are ignored.
// - Offset 0 write loads digital latch; bit drives line only if strapped output.
// - Offset 3 read returns sampled digital lines, bit n is line n.
// - Digital lines are inputs unless their direction strap is fitted.
// - Offsets 4..6 access timer channels; two-byte mode writes low then high.
// - Timer data read returns the latched count if one is held, else the current count, in the channel's byte format.
// - Control byte bits 7..6 route to channel 0..2; code 3 is read-back, which the code ignores.
// - Control byte bits 5..4 select latch, low, high, or low-then-high access.
// - Control byte bits 3..1 choose modes 0..5, top bit ignored for 2 and 3.
// - Control byte bit 0 selects binary or binary-coded decimal counting.
package adc_card_pkg;
    localparam logic [2:0] OFS_RESULT_LOW = 3'h0;
    localparam logic [2:0] OFS_RESULT_HIGH = 3'h1;
    localparam logic [2:0] OFS_STATUS_CTRL1 = 3'h2;
    localparam logic [2:0] OFS_INPUT_CTRL2 = 3'h3;
    localparam logic [2:0] OFS_TIMER0 = 3'h4;
    localparam logic [2:0] OFS_TIMER2 = 3'h6;
    localparam logic [2:0] OFS_TIMER_CTRL = 3'h7;
    localparam int BASE_LSB = 3;
    localparam int BASE_MSB = 9;
    localparam int OUT_POS = 4;
    localparam int ENABLE_POS = 3;
    localparam int USER_POS = 3;
    localparam int BUSY_POS = 7;
    localparam int IRQ_POS = 3;
    localparam int GAIN_POS = 4;
    localparam int SEL_POS = 6;
    localparam int ACC_POS = 4;
    localparam int MODE_POS = 1;
    localparam int BCD_POS = 0;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] LATCH_RESET = 8'h00;
    localparam logic [1:0] SEL_READBACK = 2'h3;
    localparam logic [1:0] ACC_LATCH = 2'h0;
    localparam logic [1:0] ACC_LOW = 2'h1;
    localparam logic [1:0] ACC_HIGH = 2'h2;
    localparam logic [1:0] ACC_BOTH = 2'h3;
    localparam int CONV_TIME_NS = 10000;
    localparam int CLOCK_NS = 40;
    localparam int CONV_CYCLES = (CONV_TIME_NS + CLOCK_NS - 1) / CLOCK_NS;
    typedef enum logic [1:0] {
        CONV_IDLE = 2'b01,
        CONV_BUSY = 2'b10
    } conv_state_t;
endpackage

// ===== verilog/adc_card_io_registers.sv
`timescale 1ns/100ps
module adc_card_io_registers #(
    parameter int CONV_CYCLES = adc_card_pkg::CONV_CYCLES,
    parameter logic [6:0] BASE_DEFAULT = 7'h60
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic [9:0] io_addr,
    input wire logic io_rd,
    input wire logic io_wr,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata,
    output logic io_hit,
    input wire logic [6:0] base_switch,
    input wire logic [11:0] conversion_result_bits,
    output logic conv_start,
    output logic [3:0] general_outputs,
    output logic interrupt_gate,
    output logic [2:0] mux_channel_select,
    output logic user_output,
    output logic [2:0] gain_select_lines,
    output logic irq_req,
    input wire logic [7:0] direction_straps,
    input wire logic [7:0] digital_lines_in,
    output logic [7:0] digital_lines_out,
    output logic [7:0] digital_lines_oe,
    output logic [1:0] timer_mode_bcd_ch0,
    output logic [3:0] timer_mode_field_ch0
);
    // Address decode against switch base
    logic sel;
    logic [2:0] ofs;
    logic rd_hit;
    logic wr_hit;
    assign sel = (io_addr[adc_card_pkg::BASE_MSB:adc_card_pkg::BASE_LSB] == base_switch);
    assign ofs = io_addr[2:0];
    assign rd_hit = sel && io_rd;
    assign wr_hit = sel && io_wr;

    // Control, latch and status state
    logic [3:0] gen_q, gen_d;
    logic ien_q, ien_d;
    logic [2:0] mux_q, mux_d;
    logic user_q, user_d;
    logic [2:0] gain_q, gain_d;
    logic [7:0] latch_q, latch_d;
    logic irqst_q, irqst_d;
    logic irq_q, irq_d;
    logic [11:0] result_q, result_d;
    logic start_q, start_d;
    adc_card_pkg::conv_state_t state_q, state_d;
    logic [15:0] cnt_q, cnt_d;
    logic done;
    assign done = (state_q == adc_card_pkg::CONV_BUSY) && (cnt_q == 16'h0000);

    always_comb begin
        gen_d = gen_q;
        ien_d = ien_q;
        mux_d = mux_q;
        user_d = user_q;
        gain_d = gain_q;
        latch_d = latch_q;
        irqst_d = irqst_q;
        irq_d = 1'b0;
        result_d = result_q;
        start_d = 1'b0;
        state_d = state_q;
        cnt_d = cnt_q;
        if (wr_hit && ofs == adc_card_pkg::OFS_STATUS_CTRL1) begin
            gen_d = io_wdata[7:adc_card_pkg::OUT_POS];
            ien_d = io_wdata[adc_card_pkg::ENABLE_POS];
            mux_d = io_wdata[2:0];
            irqst_d = 1'b0;
        end
        if (wr_hit && ofs == adc_card_pkg::OFS_INPUT_CTRL2) begin
            gen_d = io_wdata[7:adc_card_pkg::OUT_POS];
            user_d = io_wdata[adc_card_pkg::USER_POS];
            gain_d = io_wdata[2:0];
            irqst_d = 1'b0;
        end
        if (wr_hit && ofs == adc_card_pkg::OFS_RESULT_LOW) begin
            latch_d = io_wdata;
        end
        unique case (state_q)
            adc_card_pkg::CONV_IDLE: begin
                if (wr_hit && ofs == adc_card_pkg::OFS_RESULT_HIGH) begin
                    state_d = adc_card_pkg::CONV_BUSY;
                    cnt_d = 16'(CONV_CYCLES - 1);
                    start_d = 1'b1;
                    irqst_d = 1'b0;
                end
            end
            adc_card_pkg::CONV_BUSY: begin
                if (done) begin
                    state_d = adc_card_pkg::CONV_IDLE;
                    result_d = conversion_result_bits;
                    if (ien_q) begin
                        irqst_d = 1'b1;
                        irq_d = 1'b1;
                    end
                end else begin
                    cnt_d = cnt_q - 16'h0001;
                end
            end
            default: state_d = adc_card_pkg::CONV_IDLE;
        endcase
    end

    // Register control state; reset leaves interrupts off and channel zero
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            gen_q <= adc_card_pkg::CTRL_RESET[7:4];
            ien_q <= 1'b0;
            mux_q <= adc_card_pkg::CTRL_RESET[2:0];
            user_q <= 1'b0;
            gain_q <= adc_card_pkg::CTRL_RESET[2:0];
            latch_q <= adc_card_pkg::LATCH_RESET;
            irqst_q <= 1'b0;
            irq_q <= 1'b0;
            result_q <= 12'h000;
            start_q <= 1'b0;
            state_q <= adc_card_pkg::CONV_IDLE;
            cnt_q <= 16'h0000;
        end else begin
            gen_q <= gen_d;
            ien_q <= ien_d;
            mux_q <= mux_d;
            user_q <= user_d;
            gain_q <= gain_d;
            latch_q <= latch_d;
            irqst_q <= irqst_d;
            irq_q <= irq_d;
            result_q <= result_d;
            start_q <= start_d;
            state_q <= state_d;
            cnt_q <= cnt_d;
        end
    end

    // Timer channel programming and data ports
    logic [1:0] acc_q [3], acc_d [3];
    logic [2:0] mode_q [3], mode_d [3];
    logic bcd_q [3], bcd_d [3];
    logic [15:0] count_q [3], count_d [3];
    logic [15:0] hold_q [3], hold_d [3];
    logic held_q [3], held_d [3];
    logic hib_q [3], hib_d [3];
    logic [1:0] tsel;
    logic [7:0] tbyte;
    assign tsel = 2'(ofs - adc_card_pkg::OFS_TIMER0);

    always_comb begin
        logic [15:0] src;
        src = 16'h0000;
        for (int i = 0; i < 3; i++) begin
            acc_d[i] = acc_q[i];
            mode_d[i] = mode_q[i];
            bcd_d[i] = bcd_q[i];
            count_d[i] = count_q[i];
            hold_d[i] = hold_q[i];
            held_d[i] = held_q[i];
            hib_d[i] = hib_q[i];
        end
        if (wr_hit && ofs == adc_card_pkg::OFS_TIMER_CTRL &&
            io_wdata[7:adc_card_pkg::SEL_POS] != adc_card_pkg::SEL_READBACK) begin
            for (int i = 0; i < 3; i++) begin
                if (io_wdata[7:adc_card_pkg::SEL_POS] == 2'(i)) begin
                    if (io_wdata[5:adc_card_pkg::ACC_POS] == adc_card_pkg::ACC_LATCH) begin
                        hold_d[i] = count_q[i];
                        held_d[i] = 1'b1;
                    end else begin
                        acc_d[i] = io_wdata[5:adc_card_pkg::ACC_POS];
                        mode_d[i] = io_wdata[adc_card_pkg::MODE_POS+:3];
                        if (io_wdata[adc_card_pkg::MODE_POS+1])
                            mode_d[i][2] = 1'b0;
                        bcd_d[i] = io_wdata[adc_card_pkg::BCD_POS];
                        hib_d[i] = 1'b0;
                        held_d[i] = 1'b0;
                    end
                end
            end
        end
        tbyte = 8'h00;
        if (ofs >= adc_card_pkg::OFS_TIMER0 && ofs <= adc_card_pkg::OFS_TIMER2) begin
            for (int i = 0; i < 3; i++) begin
                if (tsel == 2'(i)) begin
                    src = held_q[i] ? hold_q[i] : count_q[i];
                    unique case (acc_q[i])
                        adc_card_pkg::ACC_HIGH: tbyte = src[15:8];
                        adc_card_pkg::ACC_BOTH: tbyte = hib_q[i] ? src[15:8] : src[7:0];
                        default: tbyte = src[7:0];
                    endcase
                    if (wr_hit) begin
                        unique case (acc_q[i])
                            adc_card_pkg::ACC_HIGH: count_d[i][15:8] = io_wdata;
                            adc_card_pkg::ACC_BOTH: begin
                                if (hib_q[i]) count_d[i][15:8] = io_wdata;
                                else count_d[i][7:0] = io_wdata;
                                hib_d[i] = !hib_q[i];
                            end
                            default: count_d[i][7:0] = io_wdata;
                        endcase
                    end else if (rd_hit) begin
                        if (acc_q[i] == adc_card_pkg::ACC_BOTH) hib_d[i] = !hib_q[i];
                        if (acc_q[i] != adc_card_pkg::ACC_BOTH || hib_q[i]) held_d[i] = 1'b0;
                    end
                end
            end
        end
    end

    // Register timer channel state
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < 3; i++) begin
                acc_q[i] <= adc_card_pkg::ACC_LOW;
                mode_q[i] <= 3'h0;
                bcd_q[i] <= 1'b0;
                count_q[i] <= 16'h0000;
                hold_q[i] <= 16'h0000;
                held_q[i] <= 1'b0;
                hib_q[i] <= 1'b0;
            end
        end else begin
            for (int i = 0; i < 3; i++) begin
                acc_q[i] <= acc_d[i];
                mode_q[i] <= mode_d[i];
                bcd_q[i] <= bcd_d[i];
                count_q[i] <= count_d[i];
                hold_q[i] <= hold_d[i];
                held_q[i] <= held_d[i];
                hib_q[i] <= hib_d[i];
            end
        end
    end

    // Read data mux and registered outputs
    logic [7:0] rdata_d;
    always_comb begin
        rdata_d = 8'h00;
        unique case (ofs)
            adc_card_pkg::OFS_RESULT_LOW: rdata_d = {result_q[3:0], gen_q};
            adc_card_pkg::OFS_RESULT_HIGH: rdata_d = result_q[11:4];
            adc_card_pkg::OFS_STATUS_CTRL1:
                rdata_d = {state_q == adc_card_pkg::CONV_BUSY, gain_q, irqst_q, mux_q};
            adc_card_pkg::OFS_INPUT_CTRL2: rdata_d = digital_lines_in;
            adc_card_pkg::OFS_TIMER_CTRL: rdata_d = 8'h00;
            default: rdata_d = tbyte;
        endcase
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            io_rdata <= 8'h00;
            io_hit <= 1'b0;
            digital_lines_out <= 8'h00;
            digital_lines_oe <= 8'h00;
            timer_mode_bcd_ch0 <= 2'h0;
            timer_mode_field_ch0 <= 4'h0;
        end else begin
            io_rdata <= rd_hit ? rdata_d : 8'h00;
            io_hit <= rd_hit;
            digital_lines_out <= latch_d & direction_straps;
            digital_lines_oe <= direction_straps;
            timer_mode_bcd_ch0 <= {held_q[0], bcd_q[0]};
            timer_mode_field_ch0 <= {acc_q[0][0], mode_q[0]};
        end
    end

    assign conv_start = start_q;
    assign general_outputs = gen_q;
    assign interrupt_gate = ien_q;
    assign mux_channel_select = mux_q;
    assign user_output = user_q;
    assign gain_select_lines = gain_q;
    assign irq_req = irq_q;

    // Checks
    sequence start_write;
        wr_hit && ofs == adc_card_pkg::OFS_RESULT_HIGH && state_q == adc_card_pkg::CONV_IDLE;
    endsequence
    chk_busy_after_start: assert property (@(posedge clock) disable iff (!rstn)
        start_write |=> state_q == adc_card_pkg::CONV_BUSY && !irqst_q)
        else $error("busy not raised by start write");
    chk_ctrl_clears_irq: assert property (@(posedge clock) disable iff (!rstn)
        wr_hit && (ofs == adc_card_pkg::OFS_STATUS_CTRL1 || ofs == adc_card_pkg::OFS_INPUT_CTRL2)
        && !done |=> !irqst_q)
        else $error("control write left irq status set");
    chk_irq_pairs_status: assert property (@(posedge clock) disable iff (!rstn)
        irq_q |-> irqst_q && $past(ien_q))
        else $error("irq request without status");
    chk_result_stable: assert property (@(posedge clock) disable iff (!rstn)
        !done |=> $stable(result_q))
        else $error("result changed without conversion end");
    chk_result_capture: assert property (@(posedge clock) disable iff (!rstn)
        done |=> result_q == $past(conversion_result_bits))
        else $error("result not captured");
    chk_status_echo: assert property (@(posedge clock) disable iff (!rstn)
        rd_hit && ofs == adc_card_pkg::OFS_STATUS_CTRL1 |=> io_rdata[6:4] == gain_q && io_rdata[2:0] == mux_q)
        else $error("status echo wrong");
    chk_low_byte: assert property (@(posedge clock) disable iff (!rstn)
        rd_hit && ofs == adc_card_pkg::OFS_RESULT_LOW |=> io_rdata[3:0] == $past(gen_q))
        else $error("low byte output readback wrong");
    chk_line_drive: assert property (@(posedge clock) disable iff (!rstn)
        1'b1 |=> (digital_lines_out & ~$past(direction_straps)) == 8'h00)
        else $error("line driven without strap");
endmodule // adc_card_io_registers

// ===== verification/adc_card_far_side.sv
`timescale 1ns/100ps
module adc_card_far_side (
    input wire logic clock,
    input wire logic conv_start,
    input wire logic [11:0] sample_value,
    input wire logic [7:0] lines_out,
    input wire logic [7:0] lines_oe,
    input wire logic [7:0] ext_level,
    output logic [11:0] conversion_result_bits,
    output logic [7:0] lines_in
);
    // Converter takes the analog sample at each start and holds it
    always_ff @(posedge clock) begin
        if (conv_start) begin
            conversion_result_bits <= sample_value;
        end
    end
    // Strapped lines carry the card's level, the rest the outside world
    assign lines_in = (lines_oe & lines_out) | (~lines_oe & ext_level);
endmodule // adc_card_far_side

// ===== verification/adc_card_io_registers_tb.sv
`timescale 1ns/100ps
module adc_card_io_registers_tb;
    localparam logic [6:0] BASE = 7'h60;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic [9:0] io_addr = 10'h000;
    logic io_rd = 1'b0;
    logic io_wr = 1'b0;
    logic [7:0] io_wdata = 8'h00;
    logic [7:0] straps = 8'h00;
    logic [7:0] ext_level = 8'h00;
    logic [11:0] sample_value = 12'h000;
    logic [7:0] io_rdata, lines_out, lines_oe, lines_in;
    logic [11:0] result_bits;
    logic [3:0] general_outputs, mode_field;
    logic [2:0] mux, gain;
    logic [1:0] mode_bcd;
    logic io_hit, conv_start, gate, user_output, irq_req;
    int fails = 0;
    int checked = 0;

    adc_card_io_registers #(.CONV_CYCLES(8)) i_dut (.clock(clock), .rstn(rstn), .io_addr(io_addr),
        .io_rd(io_rd), .io_wr(io_wr), .io_wdata(io_wdata), .io_rdata(io_rdata), .io_hit(io_hit),
        .base_switch(BASE), .conversion_result_bits(result_bits), .conv_start(conv_start),
        .general_outputs(general_outputs), .interrupt_gate(gate), .mux_channel_select(mux),
        .user_output(user_output), .gain_select_lines(gain), .irq_req(irq_req), .direction_straps(straps),
        .digital_lines_in(lines_in), .digital_lines_out(lines_out), .digital_lines_oe(lines_oe),
        .timer_mode_bcd_ch0(mode_bcd), .timer_mode_field_ch0(mode_field));
    adc_card_far_side i_far (.clock(clock), .conv_start(conv_start), .sample_value(sample_value),
        .lines_out(lines_out), .lines_oe(lines_oe), .ext_level(ext_level),
        .conversion_result_bits(result_bits), .lines_in(lines_in));

    // Free-running bus clock
    always #20 clock = ~clock;

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic io_write(input logic [2:0] ofs, input logic [7:0] data);
        @(posedge clock);
        io_addr <= {BASE, ofs};
        io_wdata <= data;
        io_wr <= 1'b1;
        @(posedge clock);
        io_wr <= 1'b0;
    endtask
    task automatic io_read(input logic [9:0] addr, output logic [7:0] data, output logic hit);
        @(posedge clock);
        io_addr <= addr;
        io_rd <= 1'b1;
        @(posedge clock);
        io_rd <= 1'b0;
        #1;
        data = io_rdata;
        hit = io_hit;
    endtask
    task automatic rd_chk(input string what, input logic [2:0] ofs, input logic [7:0] exp);
        logic [7:0] d;
        logic h;
        io_read({BASE, ofs}, d, h);
        check(what, d, exp);
    endtask
    task automatic settle();
        repeat (2) @(posedge clock);
        #1;
    endtask
    // Start a conversion and report whether a request pulse came
    task automatic run_conv(input logic [11:0] value, input logic [7:0] busy_status, output logic seen);
        sample_value <= value;
        io_write(3'h1, 8'h00);
        #1;
        check("start pulse", conv_start, 1'b1);
        rd_chk("busy status", 3'h2, busy_status);
        seen = 1'b0;
        repeat (30) begin
            @(posedge clock);
            #1;
            seen = seen | (irq_req === 1'b1);
        end
    endtask

    task automatic test_reset();
        check("outputs", {general_outputs, gate, mux, user_output, gain}, 12'h000);
        rd_chk("status", 3'h2, 8'h00);
        $display("test reset done");
    endtask
    task automatic test_controls();
        io_write(3'h2, 8'ha5);
        settle();
        check("ctrl1 lines", {general_outputs, gate, mux}, 12'h0a5);
        io_write(3'h3, 8'h5e);
        settle();
        check("ctrl2 lines", {general_outputs, user_output, gain}, 12'h05e);
        check("ctrl1 kept", {gate, mux}, 12'h005);
        rd_chk("status echo", 3'h2, 8'h65);
        $display("test controls done");
    endtask
    task automatic test_decode();
        logic [7:0] d;
        logic h;
        io_read({7'h61, 3'h2}, d, h);
        check("foreign hit", {h, d}, 12'h000);
        io_read({BASE, 3'h2}, d, h);
        check("own hit", h, 1'b1);
        rd_chk("unused offset", 3'h7, 8'h00);
        $display("test decode done");
    endtask
    task automatic test_conversion();
        logic seen;
        io_write(3'h3, 8'h30);
        io_write(3'h2, 8'h3d);
        run_conv(12'habc, 8'h85, seen);
        check("irq pulse", seen, 1'b1);
        rd_chk("irq status", 3'h2, 8'h0d);
        rd_chk("low byte", 3'h0, 8'hc3);
        rd_chk("high byte", 3'h1, 8'hab);
        io_write(3'h2, 8'h3d);
        rd_chk("irq cleared", 3'h2, 8'h05);
        sample_value <= 12'h123;
        io_write(3'h1, 8'hff);
        rd_chk("low held", 3'h0, 8'hc3);
        rd_chk("high held", 3'h1, 8'hab);
        repeat (20) @(posedge clock);
        rd_chk("new low", 3'h0, 8'h33);
        rd_chk("new high", 3'h1, 8'h12);
        io_write(3'h2, 8'h35);
        run_conv(12'h456, 8'h85, seen);
        check("no irq pulse", seen, 1'b0);
        rd_chk("no irq status", 3'h2, 8'h05);
        $display("test conversion done");
    endtask
    task automatic test_digital();
        check("lines idle", {lines_out, lines_oe}, 16'h0000);
        @(posedge clock);
        straps <= 8'h0f;
        ext_level <= 8'hc3;
        io_write(3'h0, 8'h5a);
        settle();
        check("line drive", lines_out, 8'h0a);
        check("line enable", lines_oe, 8'h0f);
        rd_chk("line read", 3'h3, 8'hca);
        rd_chk("result kept", 3'h1, 8'h45);
        $display("test digital done");
    endtask
    task automatic test_timer();
        io_write(3'h7, 8'h30);
        settle();
        check("ch0 format", {mode_bcd, mode_field}, 12'h008);
        io_write(3'h4, 8'h34);
        io_write(3'h4, 8'h12);
        rd_chk("count low", 3'h4, 8'h34);
        rd_chk("count high", 3'h4, 8'h12);
        io_write(3'h7, 8'h1f);
        io_write(3'h7, 8'hf0);
        io_write(3'h7, 8'h70);
        settle();
        check("ch0 mode3 bcd", {mode_bcd, mode_field}, 12'h01b);
        io_write(3'h4, 8'h77);
        rd_chk("low only", 3'h4, 8'h77);
        io_write(3'h7, 8'h00);
        io_write(3'h4, 8'h99);
        rd_chk("latched low", 3'h4, 8'h77);
        rd_chk("live low", 3'h4, 8'h99);
        io_write(3'h7, 8'h90);
        io_write(3'h6, 8'h5c);
        rd_chk("ch2 low", 3'h6, 8'h5c);
        $display("test timer done");
    endtask

    task automatic test_done();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Main sequence after a two-cycle reset
    initial begin
        repeat (2) @(posedge clock);
        rstn <= 1'b1;
        #1;
        test_reset();
        test_controls();
        test_decode();
        test_conversion();
        test_digital();
        test_timer();
        test_done();
    end
    // Hang guard, far beyond the expected few hundred cycles
    initial begin
        #400000;
        fails++;
        test_done();
    end
endmodule // adc_card_io_registers_tb
